// ==== sbcl_pkg.sv ====
// Shared constants and carrier types for the storage bus command lookahead core
package sbcl_pkg;

   // Addressing widths and counts
   localparam int MAX_DRIVES  = 8;                      // Drives per controller
   localparam int NUM_CS      = 8;                      // Controller select codes in the system
   localparam int CS_W        = 3;                      // Controller select code width
   localparam int DS_W        = 3;                      // Drive select code width
   localparam int RS_W        = 5;                      // Register select code width
   localparam int NUM_REGS    = 32;                     // Register address space per drive
   localparam int DATA_W      = 16;                     // Control bus data width

   // Register select of the drive control register, the target of seek and rewind
   localparam logic [RS_W-1:0] REG_CTRL = 5'h00;

   // Reset values
   localparam logic [CS_W-1:0]   CS_RST   = 3'h0;
   localparam logic [DS_W-1:0]   DS_RST   = 3'h0;
   localparam logic [RS_W-1:0]   RS_RST   = 5'h00;
   localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

   // Settle cycles between select lines and demand on the control bus
   localparam int            SETTLE_NS  = 10;
   localparam int            CLK_NS     = 10;
   localparam int            SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [1:0]    SETTLE_CNT = 2'(SETTLE_CYC);

   // Host request kinds
   typedef enum logic [1:0]
   {
      OP_LOAD_XFER,
      OP_REG_WRITE,
      OP_REG_READ,
      OP_CLR_ERR
   } sbcl_op_t;

   // Request from the host processor side
   typedef struct packed
   {
      logic              valid;
      logic [CS_W-1:0]   ctl_code;
      sbcl_op_t          op;
      logic              xfer;
      logic              wr;
      logic [DS_W-1:0]   drive;
      logic [RS_W-1:0]   regsel;
      logic [DATA_W-1:0] data;
   } sbcl_req_t;

   // Control bus lines driven toward the drives
   typedef struct packed
   {
      logic [DS_W-1:0]   drive_select_code;
      logic [RS_W-1:0]   register_select_code;
      logic              ctod;
      logic              dem;
      logic [DATA_W-1:0] data;
   } sbcl_bus_t;

   // Lines coming back from the drives and the data channel
   typedef struct packed
   {
      logic              tra;
      logic [DATA_W-1:0] rdata;
      logic              attn;
      logic              xfer_done;
      logic              xfer_err;
   } sbcl_drv_in_t;

   // Status toward the host processor
   typedef struct packed
   {
      logic              req_ack;
      logic              req_err;
      logic              rd_valid;
      logic [DATA_W-1:0] rd_data;
      logic              xfer_go;
      logic [DS_W-1:0]   xfer_drive;
      logic              xfer_wr;
      logic              xfer_err;
      logic              int_req;
      logic [CS_W-1:0]   int_slot;
   } sbcl_stat_t;

endpackage

// ==== sbcl_ctl_port.sv ====
// Control bus handshake engine for one external register access
`timescale 1ns/1ns
module sbcl_ctl_port
(
   input  wire logic                        i_core_clk,
   input  wire logic                        i_rst_n,
   input  wire logic                        i_go,
   input  wire logic [sbcl_pkg::DS_W-1:0]   i_drive,
   input  wire logic [sbcl_pkg::RS_W-1:0]   i_regsel,
   input  wire logic                        i_wr,
   input  wire logic [sbcl_pkg::DATA_W-1:0] i_wdata,
   input  wire logic                        i_tra,
   input  wire logic [sbcl_pkg::DATA_W-1:0] i_rdata,
   output sbcl_pkg::sbcl_bus_t              o_bus,
   output logic                             o_done,
   output logic [sbcl_pkg::DATA_W-1:0]      o_rdata
);

   typedef enum logic [1:0]
   {
      P_IDLE,
      P_SETUP,
      P_DEMAND,
      P_RELEASE
   } sbcl_pst_t;

   typedef struct packed
   {
      sbcl_pst_t                    fsm;
      logic [1:0]                   cnt;
      sbcl_pkg::sbcl_bus_t          bus;
      logic                         done;
      logic [sbcl_pkg::DATA_W-1:0]  rdata;
   } sbcl_pstate_t;

   sbcl_pstate_t st_reg;
   sbcl_pstate_t st_next;

   // Select lines settle before demand, demand drops only after transfer answers
   always_comb
   begin
      st_next      = st_reg;
      st_next.done = 1'b0;
      unique case (st_reg.fsm)
         P_IDLE:
         begin
            if (i_go)
            begin
               st_next.bus.drive_select_code    = i_drive;   // [RULE14]
               st_next.bus.register_select_code = i_regsel;  // [RULE15]
               st_next.bus.ctod                 = i_wr;
               st_next.bus.data                 = i_wr ? i_wdata : sbcl_pkg::DATA_RST;
               st_next.cnt                      = sbcl_pkg::SETTLE_CNT;
               st_next.fsm                      = P_SETUP;
            end
         end
         P_SETUP:
         begin
            if (st_reg.cnt <= 2'h1)
            begin
               st_next.bus.dem = 1'b1;
               st_next.fsm     = P_DEMAND;
            end
            else
            begin
               st_next.cnt = st_reg.cnt - 2'h1;
            end
         end
         P_DEMAND:
         begin
            if (i_tra)
            begin
               st_next.rdata   = i_rdata;                     // Drive holds data while transfer is up
               st_next.bus.dem = 1'b0;
               st_next.fsm     = P_RELEASE;
            end
         end
         P_RELEASE:
         begin
            if (!i_tra)
            begin
               st_next.bus.ctod = 1'b0;
               st_next.done     = 1'b1;
               st_next.fsm      = P_IDLE;
            end
         end
      endcase
   end

   // State register
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         st_reg <= '{fsm: P_IDLE, cnt: 2'h0,
                     bus: '{sbcl_pkg::DS_RST, sbcl_pkg::RS_RST, 1'b0, 1'b0, sbcl_pkg::DATA_RST},
                     done: 1'b0, rdata: sbcl_pkg::DATA_RST};
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign o_bus   = st_reg.bus;
   assign o_done  = st_reg.done;
   assign o_rdata = st_reg.rdata;

   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_rst_n);

   sequence demand_up;
      !o_bus.dem ##1 o_bus.dem;
   endsequence

   // Select codes never move while demand is up
   sel_stable_a: assert property (o_bus.dem |-> $stable(o_bus.drive_select_code)
                                  && $stable(o_bus.register_select_code)) // [RULE14]
      else $error("select code moved during demand");
   // Demand rises only after the select lines had a settle cycle
   settle_first_a: assert property (demand_up |-> $past(st_reg.fsm, 1) == P_SETUP) // [RULE15]
      else $error("demand raised without settle cycle");

endmodule

// ==== sbcl_core.sv ====
// Command lookahead and addressing core of the storage bus controller
`timescale 1ns/1ns
// Notes on behaviour
// [RULE1] Address and control up to eight drives
// [RULE2] Only one drive transfers data at once
// [RULE3] Non-transfer access allowed unless drive transferring; the code refuses only control register writes to that drive
// [RULE4] Answer only to own controller select code
// [RULE5] Device code addresses, slot number identifies interrupt
// [RULE6] Drive addressed by its own fixed code
// [RULE7] Common registers internal, drive registers external
// [RULE8] Register space holds thirty-two registers
// [RULE9] Primary and secondary transfer command registers
// [RULE10] Primary starts at once unless transfer error
// [RULE11] Secondary starts when primary done, no error
// [RULE12] Software loads only read or write commands
// [RULE13] Interrupt on done, enabled attention, access error
// [RULE14] Drive three-bit drive select code
// [RULE15] Drive five-bit register select code
// [RULE16] Transfer error holds pending secondary command
module sbcl_core
#(
   parameter int NUM_DRIVES = sbcl_pkg::MAX_DRIVES
)
(
   input  wire logic                        i_core_clk,
   input  wire logic                        i_nrst,
   input  wire logic [sbcl_pkg::CS_W-1:0]   i_dev_code,
   input  wire logic [sbcl_pkg::CS_W-1:0]   i_slot_num,
   input  sbcl_pkg::sbcl_req_t              i_req,
   input  wire logic                        i_attn_ie,
   input  wire logic                        i_int_ack,
   input  sbcl_pkg::sbcl_drv_in_t           i_drv,
   output sbcl_pkg::sbcl_bus_t              o_bus,
   output sbcl_pkg::sbcl_stat_t             o_stat
);

   if (NUM_DRIVES < 1 || NUM_DRIVES > sbcl_pkg::MAX_DRIVES)
   begin : g_bad_drives
      $error("NUM_DRIVES must lie between 1 and the drive select range");
   end
   if (sbcl_pkg::NUM_REGS != (1 << sbcl_pkg::RS_W))
   begin : g_bad_regs
      $error("register select width does not cover the register space");
   end

   // Whole state of the core
   typedef struct packed
   {
      logic                         strap_done;
      logic [sbcl_pkg::CS_W-1:0]    dev_code;
      logic [sbcl_pkg::CS_W-1:0]    slot;
      logic                         pri_v;
      logic                         pri_wr;
      logic [sbcl_pkg::DS_W-1:0]    pri_drv;
      logic                         sec_v;
      logic                         sec_wr;
      logic [sbcl_pkg::DS_W-1:0]    sec_drv;
      logic                         active;
      logic                         xfer_err;
      logic                         attn_q;
      logic                         pend;
      logic                         pend_rd;
      logic                         port_go;
      logic [sbcl_pkg::DS_W-1:0]    port_drv;
      logic [sbcl_pkg::RS_W-1:0]    port_rs;
      logic                         port_wr;
      logic [sbcl_pkg::DATA_W-1:0]  port_data;
      logic                         req_ack;
      logic                         req_err;
      logic                         rd_valid;
      logic [sbcl_pkg::DATA_W-1:0]  rd_data;
      logic                         xfer_go;
      logic                         int_req;
   } sbcl_state_t;

   localparam logic [sbcl_pkg::DS_W:0] DRV_LIMIT = (sbcl_pkg::DS_W+1)'(NUM_DRIVES);

   sbcl_state_t                 st_reg;
   sbcl_state_t                 st_next;
   logic [1:0]                  rst_sync_reg;
   logic                        rst_n;
   logic                        port_done;
   logic [sbcl_pkg::DATA_W-1:0] port_rdata;
   logic                        addr_hit;
   logic                        reg_busy;

   // Drive code outside the fitted range counts as an access error
   function automatic logic drive_absent(input logic [sbcl_pkg::DS_W-1:0] drv);
      drive_absent = {1'b0, drv} >= DRV_LIMIT;                 // [RULE1]
   endfunction

   // Reset release through two flops so the core leaves reset on a clock edge
   always_ff @(posedge i_core_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         rst_sync_reg <= 2'h0;
      end
      else
      begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_reg[1];

   // A request is ours only when it carries the strapped controller code
   assign addr_hit = i_req.valid && st_reg.strap_done && (i_req.ctl_code == st_reg.dev_code); // [RULE4]
   assign reg_busy = st_reg.pend || st_reg.port_go;

   // Next state: straps, interrupt, transfer completion, issue, then host requests
   always_comb
   begin
      st_next          = st_reg;
      st_next.req_ack  = 1'b0;
      st_next.req_err  = 1'b0;
      st_next.rd_valid = 1'b0;
      st_next.xfer_go  = 1'b0;
      st_next.port_go  = 1'b0;
      st_next.attn_q   = i_drv.attn;

      // Straps are hardwired; caught once on the first edge after release
      if (!st_reg.strap_done)
      begin
         st_next.dev_code   = i_dev_code;                       // [RULE5]
         st_next.slot       = i_slot_num;                       // [RULE5]
         st_next.strap_done = 1'b1;
      end

      // Acknowledge first so any event in the same cycle re-raises the request
      if (i_int_ack)
      begin
         st_next.int_req = 1'b0;
      end
      if (addr_hit && i_req.op == sbcl_pkg::OP_CLR_ERR)
      begin
         st_next.xfer_err = 1'b0;
         st_next.req_ack  = 1'b1;
      end

      // Completion frees the channel and promotes the lookahead command
      if (st_reg.active && i_drv.xfer_done)
      begin
         st_next.active  = 1'b0;
         st_next.int_req = 1'b1;                                 // [RULE13]
         if (i_drv.xfer_err)
         begin
            st_next.xfer_err = 1'b1;                             // Set wins over a clear
         end
         st_next.pri_v   = st_reg.sec_v;                         // [RULE11]
         st_next.pri_wr  = st_reg.sec_wr;
         st_next.pri_drv = st_reg.sec_drv;
         st_next.sec_v   = 1'b0;
      end

      // Issue: a single active flag keeps one drive on the data channel
      if (st_reg.pri_v && !st_reg.active && !st_reg.xfer_err)  // [RULE10] [RULE16]
      begin
         st_next.xfer_go = 1'b1;
         st_next.active  = 1'b1;                                 // [RULE2]
      end

      // Attention edge interrupts only with its enable set
      if (i_drv.attn && !st_reg.attn_q && i_attn_ie)
      begin
         st_next.int_req = 1'b1;                                 // [RULE13]
      end

      // External access finished on the control bus
      if (port_done)
      begin
         st_next.pend = 1'b0;
         if (st_reg.pend_rd)
         begin
            st_next.rd_valid = 1'b1;
            st_next.rd_data  = port_rdata;
         end
      end

      // Host requests; register accesses wait while the control bus is busy
      if (addr_hit)
      begin
         unique case (i_req.op)
            sbcl_pkg::OP_LOAD_XFER:
            begin
               st_next.req_ack = 1'b1;
               // Seek and rewind belong in the drive, not in the command registers
               if (!i_req.xfer || drive_absent(i_req.drive) || (st_next.pri_v && st_next.sec_v)) // [RULE12]
               begin
                  st_next.req_err = 1'b1;
                  st_next.int_req = 1'b1;                        // [RULE13]
               end
               else if (!st_next.pri_v)
               begin
                  st_next.pri_v   = 1'b1;                        // [RULE9]
                  st_next.pri_wr  = i_req.wr;
                  st_next.pri_drv = i_req.drive;
               end
               else
               begin
                  st_next.sec_v   = 1'b1;                        // [RULE9]
                  st_next.sec_wr  = i_req.wr;
                  st_next.sec_drv = i_req.drive;
               end
            end
            sbcl_pkg::OP_REG_WRITE,
            sbcl_pkg::OP_REG_READ:
            begin
               if (!reg_busy)
               begin
                  st_next.req_ack = 1'b1;
                  // Control writes to the transferring drive would disturb the transfer
                  if (drive_absent(i_req.drive) ||
                      (i_req.op == sbcl_pkg::OP_REG_WRITE && i_req.regsel == sbcl_pkg::REG_CTRL &&
                       st_reg.active && st_reg.pri_drv == i_req.drive)) // [RULE3]
                  begin
                     st_next.req_err = 1'b1;
                     st_next.int_req = 1'b1;                     // [RULE13]
                  end
                  else
                  begin
                     st_next.port_go   = 1'b1;                   // [RULE7]
                     st_next.pend      = 1'b1;
                     st_next.pend_rd   = (i_req.op == sbcl_pkg::OP_REG_READ);
                     st_next.port_drv  = i_req.drive;            // [RULE6]
                     st_next.port_rs   = i_req.regsel;           // [RULE8]
                     st_next.port_wr   = (i_req.op == sbcl_pkg::OP_REG_WRITE);
                     st_next.port_data = i_req.data;
                  end
               end
            end
            sbcl_pkg::OP_CLR_ERR:
            begin
               st_next.req_ack = 1'b1;
            end
         endcase
      end
   end

   // State register
   always_ff @(posedge i_core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // Control bus handshake for external registers
   sbcl_ctl_port u_port
   (
      .i_core_clk (i_core_clk),
      .i_rst_n    (rst_n),
      .i_go       (st_reg.port_go),
      .i_drive    (st_reg.port_drv),
      .i_regsel   (st_reg.port_rs),
      .i_wr       (st_reg.port_wr),
      .i_wdata    (st_reg.port_data),
      .i_tra      (i_drv.tra),
      .i_rdata    (i_drv.rdata),
      .o_bus      (o_bus),
      .o_done     (port_done),
      .o_rdata    (port_rdata)
   );

   // Status outputs straight from state flops
   assign o_stat.req_ack    = st_reg.req_ack;
   assign o_stat.req_err    = st_reg.req_err;
   assign o_stat.rd_valid   = st_reg.rd_valid;
   assign o_stat.rd_data    = st_reg.rd_data;
   assign o_stat.xfer_go    = st_reg.xfer_go;
   assign o_stat.xfer_drive = st_reg.pri_drv;
   assign o_stat.xfer_wr    = st_reg.pri_wr;
   assign o_stat.xfer_err   = st_reg.xfer_err;
   assign o_stat.int_req    = st_reg.int_req;
   assign o_stat.int_slot   = st_reg.slot;                       // [RULE5]

   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!rst_n);

   sequence clean_done_with_next;
      st_reg.active && i_drv.xfer_done && !i_drv.xfer_err && st_reg.sec_v;
   endsequence
   sequence promoted_then_go;
      (st_reg.pri_v && !st_reg.active) ##1 st_reg.xfer_go;
   endsequence

   one_xfer_a: assert property (st_reg.active |=> !st_reg.xfer_go || !$past(st_reg.active)) // [RULE2]
      else $error("second transfer started while one active");
   pri_start_a: assert property (st_reg.pri_v && !st_reg.active && !st_reg.xfer_err
                                 |=> st_reg.xfer_go && st_reg.active) // [RULE10]
      else $error("primary command did not start");
   sec_follow_a: assert property (clean_done_with_next |=> promoted_then_go) // [RULE11]
      else $error("lookahead command did not follow");
   err_hold_a: assert property (st_reg.xfer_err && !st_reg.active && !i_int_ack |=> !st_reg.xfer_go) // [RULE16]
      else $error("command started under transfer error");
   done_irq_a: assert property (st_reg.active && i_drv.xfer_done |=> st_reg.int_req && !st_reg.active) // [RULE13]
      else $error("no interrupt on transfer done");
   code_only_a: assert property (st_reg.req_ack |-> $past(i_req.ctl_code) == st_reg.dev_code
                                 && $past(i_req.valid)) // [RULE4]
      else $error("answered a foreign controller code");
   ctl_guard_a: assert property (addr_hit && i_req.op == sbcl_pkg::OP_REG_WRITE && !reg_busy && st_reg.active
                                 && i_req.regsel == sbcl_pkg::REG_CTRL && i_req.drive == st_reg.pri_drv
                                 |=> st_reg.req_err && !st_reg.port_go) // [RULE3]
      else $error("control write reached a transferring drive");
   drive_range_a: assert property (st_reg.port_go |-> !drive_absent(st_reg.port_drv)) // [RULE1]
      else $error("access issued to an absent drive");
   slot_out_a: assert property (st_reg.strap_done && $past(st_reg.strap_done) |-> o_stat.int_slot == st_reg.slot
                                && $stable(st_reg.slot)) // [RULE5]
      else $error("interrupt slot number changed");

endmodule

// ==== sbcl_drv_model.sv ====
// Behavioural bank of eight drives answering the control bus
`timescale 1ns/1ns
module sbcl_drv_model
(
   input  wire logic           i_core_clk,
   input  sbcl_pkg::sbcl_bus_t i_bus,
   input  wire logic           i_slow,
   output logic                o_tra,
   output logic [15:0]         o_rdata
);
   logic [15:0] mem_reg [8][32];
   int          wait_cnt;

   // Each unit answers only to its own fixed code; its registers live here
   initial
   begin
      for (int d = 0; d < 8; d++)
         for (int r = 0; r < 32; r++)
            mem_reg[d][r] = {8'hA5 ^ 8'(d), 3'h0, 5'(r)};
      o_tra = 1'b0;
      o_rdata = 16'h0000;
      wait_cnt = 0;
   end

   // Answer a demand, slowly when asked; a released data line shows the inverse, not the old word
   always @(posedge i_core_clk)
   begin
      if (i_bus.dem && !o_tra)
      begin
         if (wait_cnt < (i_slow ? 6 : 0))
            wait_cnt <= wait_cnt + 1;
         else
         begin
            wait_cnt <= 0;
            o_tra <= 1'b1;
            if (i_bus.ctod)
               mem_reg[i_bus.drive_select_code][i_bus.register_select_code] <= i_bus.data;
            else
               o_rdata <= mem_reg[i_bus.drive_select_code][i_bus.register_select_code];
         end
      end
      else if (!i_bus.dem && o_tra)
      begin
         o_tra <= 1'b0;
         o_rdata <= ~o_rdata;
      end
   end
endmodule

// ==== sbcl_core_tb.sv ====
// Self-checking bench for the storage bus command lookahead core
`timescale 1ns/1ns
module sbcl_core_tb;
   localparam logic [2:0] DEV  = 3'h5;
   localparam logic [2:0] SLOT = 3'h2;
   logic                   clk;
   logic                   nrst;
   logic                   attn_ie;
   logic                   int_ack;
   logic                   slow;
   logic                   tra;
   logic                   attn;
   logic                   xd;
   logic                   xe;
   logic                   ack_seen;
   logic                   err_seen;
   logic [15:0]            rdata;
   int                     n_fail;
   int                     checked;
   sbcl_pkg::sbcl_req_t    req;
   sbcl_pkg::sbcl_drv_in_t drv;
   sbcl_pkg::sbcl_bus_t    bus;
   sbcl_pkg::sbcl_stat_t   stat;

   // Drive answer lines come from the model, channel lines from the bench
   assign drv = {tra, rdata, attn, xd, xe};

   sbcl_core #(.NUM_DRIVES(8)) sbcl_core_inst (.i_core_clk(clk), .i_nrst(nrst), .i_dev_code(DEV),
      .i_slot_num(SLOT), .i_req(req), .i_attn_ie(attn_ie), .i_int_ack(int_ack), .i_drv(drv),
      .o_bus(bus), .o_stat(stat));
   sbcl_drv_model sbcl_drv_model_inst (.i_core_clk(clk), .i_bus(bus), .i_slow(slow), .o_tra(tra),
      .o_rdata(rdata));

   // Free running core clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic chk(input logic g, input logic e);
      checked++;
      if (g !== e)
      begin
         n_fail++;
         $display("Error at %0t: flag %b not %b", $time, g, e);
      end
   endtask

   task automatic chkw(input logic [15:0] g, input logic [15:0] e);
      checked++;
      if (g !== e)
      begin
         n_fail++;
         $display("Error at %0t: word %h not %h", $time, g, e);
      end
   endtask

   task automatic final_report();
      $display("Checks %0d, errors %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic tmo();
      chk(1'b0, 1'b1);
      final_report();
   endtask

   // Hold valid until acknowledged, then drop it in the acknowledge cycle; odd drives write
   task automatic send(input logic [2:0] cc, input sbcl_pkg::sbcl_op_t op, input logic xf,
                       input logic [2:0] ds, input logic [4:0] rs, input logic [15:0] d, input logic exp);
      ack_seen = 1'b0;
      err_seen = 1'b0;
      req = '{1'b1, cc, op, xf, ds[0], ds, rs, d};
      for (int i = 0; i < 40 && !ack_seen; i++)
      begin
         tick(1);
         ack_seen = (stat.req_ack === 1'b1);
         err_seen = (stat.req_err === 1'b1);
      end
      req.valid = 1'b0;
      if (exp && !ack_seen)
         tmo();
   endtask

   // One external register access; d is the word written or the word expected back
   task automatic reg_io(input sbcl_pkg::sbcl_op_t op, input logic [2:0] ds, input logic [4:0] rs,
                         input logic [15:0] d);
      int i;
      send(DEV, op, 1'b0, ds, rs, d, 1'b1);
      for (i = 0; i < 40 && bus.dem !== 1'b1; i++)
         tick(1);
      if (i == 40)
         tmo();
      chk(bus.drive_select_code === ds && bus.register_select_code === rs, 1'b1);
      chk(bus.ctod, op == sbcl_pkg::OP_REG_WRITE);
      chkw(bus.data, (op == sbcl_pkg::OP_REG_WRITE) ? d : 16'h0000);
      for (i = 0; i < 40 && bus.dem !== 1'b0; i++)
         tick(1);
      if (i == 40)
         tmo();
      if (op == sbcl_pkg::OP_REG_READ)
      begin
         for (i = 0; i < 40 && stat.rd_valid !== 1'b1; i++)
            tick(1);
         if (i == 40)
            tmo();
         chkw(stat.rd_data, d);
      end
   endtask

   task automatic wgo(input int n, input logic [2:0] ds, input logic exp);
      logic seen;
      seen = 1'b0;
      for (int i = 0; i < n && !seen; i++)
      begin
         tick(1);
         seen = (stat.xfer_go === 1'b1);
      end
      chk(seen, exp);
      if (seen)
         chk(stat.xfer_drive === ds && stat.xfer_wr === ds[0], 1'b1);
   endtask

   // Channel end of transfer; only ever pulsed while a transfer is active
   task automatic done(input logic e);
      xd = 1'b1;
      xe = e;
      tick(1);
      xd = 1'b0;
      xe = 1'b0;
   endtask

   task automatic clr_int();
      tick(1);
      int_ack = 1'b1;
      tick(1);
      int_ack = 1'b0;
      tick(1);
      chk(stat.int_req, 1'b0);
   endtask

   task automatic t_regs();
      for (int d = 0; d < 8; d++)
      begin
         slow = d[0];
         reg_io(sbcl_pkg::OP_REG_WRITE, 3'(d), 5'h1F, 16'hC0DE ^ 16'(d));
         reg_io(sbcl_pkg::OP_REG_READ, 3'(d), 5'h1F, 16'hC0DE ^ 16'(d));
         reg_io(sbcl_pkg::OP_REG_READ, 3'(d), 5'h0A, {8'hA5 ^ 8'(d), 8'h0A});
      end
      slow = 1'b0;
   endtask

   task automatic t_lookahead();
      send(DEV, sbcl_pkg::OP_LOAD_XFER, 1'b1, 3'h2, 5'h00, 16'h0000, 1'b1);
      wgo(3, 3'h2, 1'b1);
      send(DEV, sbcl_pkg::OP_LOAD_XFER, 1'b1, 3'h5, 5'h00, 16'h0000, 1'b1);
      wgo(5, 3'h5, 1'b0);
      send(DEV, sbcl_pkg::OP_LOAD_XFER, 1'b1, 3'h6, 5'h00, 16'h0000, 1'b1);
      chk(err_seen, 1'b1);
      tick(1);
      chk(stat.int_req, 1'b1);
      clr_int();
      send(DEV, sbcl_pkg::OP_REG_WRITE, 1'b0, 3'h2, sbcl_pkg::REG_CTRL, 16'h0001, 1'b1);
      chk(err_seen, 1'b1);
      clr_int();
      reg_io(sbcl_pkg::OP_REG_WRITE, 3'h3, sbcl_pkg::REG_CTRL, 16'h0007);
      chk(err_seen, 1'b0);
      done(1'b0);
      wgo(3, 3'h5, 1'b1);
      chk(stat.int_req, 1'b1);
      clr_int();
      done(1'b0);
      clr_int();
   endtask

   task automatic t_error();
      send(DEV, sbcl_pkg::OP_LOAD_XFER, 1'b1, 3'h1, 5'h00, 16'h0000, 1'b1);
      wgo(3, 3'h1, 1'b1);
      send(DEV, sbcl_pkg::OP_LOAD_XFER, 1'b1, 3'h4, 5'h00, 16'h0000, 1'b1);
      done(1'b1);
      wgo(8, 3'h4, 1'b0);
      chk(stat.xfer_err, 1'b1);
      chk(stat.int_req, 1'b1);
      send(DEV, sbcl_pkg::OP_CLR_ERR, 1'b0, 3'h0, 5'h00, 16'h0000, 1'b1);
      wgo(4, 3'h4, 1'b1);
      chk(stat.xfer_err, 1'b0);
      done(1'b0);
      clr_int();
      send(DEV, sbcl_pkg::OP_LOAD_XFER, 1'b0, 3'h0, 5'h00, 16'h0000, 1'b1);
      chk(err_seen, 1'b1);
      clr_int();
   endtask

   task automatic t_attn();
      attn = 1'b1;
      tick(3);
      chk(stat.int_req, 1'b0);
      attn = 1'b0;
      attn_ie = 1'b1;
      tick(1);
      attn = 1'b1;
      tick(3);
      chk(stat.int_req, 1'b1);
      attn = 1'b0;
      clr_int();
   endtask

   // Main sequence
   initial
   begin
      nrst = 1'b0;
      req = '0;
      attn_ie = 1'b0;
      int_ack = 1'b0;
      slow = 1'b0;
      attn = 1'b0;
      xd = 1'b0;
      xe = 1'b0;
      n_fail = 0;
      checked = 0;
      tick(10);
      chk(bus.dem, 1'b0);
      nrst = 1'b1;
      tick(4);
      chkw(16'(stat.int_slot), 16'(SLOT));
      send(DEV ^ 3'h1, sbcl_pkg::OP_REG_READ, 1'b0, 3'h0, 5'h00, 16'h0000, 1'b0);
      chk(ack_seen, 1'b0);
      chk(bus.dem, 1'b0);
      tick(1);
      t_regs();
      t_lookahead();
      t_error();
      t_attn();
      final_report();
   end
endmodule
